// *** shared/pfs_pkg.sv ***
// Purpose: Constants and types for the dual-timer pin function select.
// Assumes: APB with 8-bit byte addresses and 32-bit data.
// Notes: One word per register; unused bits read as zero.
package pfs_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NPIN = 4;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_OUT_DIS = 8'h08;
  localparam logic [7:0] OFS_FUNC = 8'h0C;
  localparam logic [7:0] OFS_IO_AB = 8'h10;
  localparam logic [7:0] OFS_IO_CD = 8'h14;
  localparam logic [7:0] OFS_PWM_SEL = 8'h18;
  localparam logic [7:0] OFS_PORT_DIR = 8'h1C;
  localparam logic [7:0] OFS_PORT_DATA = 8'h20;
  localparam logic [7:0] OFS_GR0 = 8'h24;
  localparam logic [7:0] OFS_GR_STEP = 8'h04;
  localparam logic [7:0] OFS_GR1 = 8'h34;
  localparam logic [7:0] OFS_CNT0 = 8'h38;
  localparam logic [7:0] OFS_CNT1 = 8'h3C;
  localparam logic [7:0] OFS_STATUS = 8'h40;

  // ==========================================================
  // Field encodings
  localparam logic [2:0] CSS_MAX_SYS = 3'h5;
  localparam logic [2:0] CSS_FAST = 3'h6;
  localparam logic [1:0] CMB_NONE = 2'h0;
  localparam logic [1:0] CMB_RSYNC = 2'h1;
  localparam logic [2:0] IO_EXTCLK = 3'h0;
  localparam logic [2:0] IO_CMP_LOW = 3'h1;
  localparam logic [2:0] IO_CMP_HIGH = 3'h2;
  localparam logic [1:0] IO_CMP_PAIR = 2'h1;

  // ==========================================================
  // Reset values
  localparam logic [3:0] OUT_DIS_RST = 4'hF;
  localparam logic [3:0] FUNC_RST = 4'h4;
  localparam logic [15:0] GR_RST = 16'hFFFF;

  // ==========================================================
  // Types
  typedef struct packed {
    logic clr_on_match;
    logic run;
    logic [2:0] count_source_sel;
  } pfs_ctrl_t;

  typedef struct packed {
    logic ext_clock_select;
    logic fixed_period_mode_bit;
    logic [1:0] combination_mode_field;
  } pfs_func_t;

  typedef struct packed {
    logic [2:0] hi_io;
    logic pin_a_extra_ctrl;
    logic [2:0] lo_io;
  } pfs_io_t;

  typedef enum logic [2:0] {
    FN_PORT, FN_CPWM, FN_RSYNC, FN_FIXED, FN_PWM, FN_CMP, FN_CAP, FN_EXTCLK
  } pfs_fn_t;
endpackage

// *** design/pfs_pin_select.sv ***
// Purpose: Pin function and mode select for channel 0 of a dual timer.
// Assumes: Pin inputs synchronous to pclk; fast oscillator as a tick.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
module pfs_pin_select
  import pfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_onchip_osc_clock,
  input wire logic [NPIN-1:0] ch0_pin_in,
  output logic [NPIN-1:0] ch0_pin_out,
  output logic [NPIN-1:0] ch0_pin_oe_n,
  output logic [1:0] op_clk_fast
);
  // ==========================================================
  // Decoding helpers
  function automatic logic op_tick(input logic [2:0] css, input logic osc);
    op_tick = 1'h0;
    if (css <= CSS_MAX_SYS) begin
      op_tick = 1'h1;
    end else if (css == CSS_FAST) begin
      op_tick = osc;
    end
  endfunction

  function automatic logic [7:0] gr_addr(input int unsigned k);
    gr_addr = OFS_GR0 + 8'(k) * OFS_GR_STEP;
  endfunction

  function automatic pfs_fn_t pin_fn(input int unsigned idx,
      input logic dis, input pfs_func_t f, input logic pwm,
      input logic extra, input logic [2:0] io);
    logic cmp_io;
    logic timer;
    logic plain;
    cmp_io = (io == IO_CMP_LOW) || (io[2:1] == IO_CMP_PAIR);
    timer = f.fixed_period_mode_bit && f.combination_mode_field == CMB_NONE;
    plain = !f.fixed_period_mode_bit && f.combination_mode_field == CMB_NONE;
    pin_fn = FN_PORT;
    if (idx == 0) begin
      if (f.fixed_period_mode_bit && f.ext_clock_select &&
          io == IO_EXTCLK) begin
        pin_fn = FN_EXTCLK;
      end else if (!f.ext_clock_select) begin
        if (!dis && plain) begin
          pin_fn = FN_FIXED;
        end else if (timer && !dis && extra && cmp_io) begin
          pin_fn = FN_CMP;
        end else if (timer && io[2]) begin
          pin_fn = FN_CAP;
        end
      end
    end else begin
      if (!dis && f.combination_mode_field[1]) begin
        pin_fn = FN_CPWM;
      end else if (!dis && f.combination_mode_field == CMB_RSYNC) begin
        pin_fn = FN_RSYNC;
      end else if (idx == 1 && !dis && plain) begin
        pin_fn = FN_FIXED;
      end else if (timer && pwm && !dis) begin
        pin_fn = FN_PWM;
      end else if (timer && !pwm && !dis && cmp_io) begin
        pin_fn = FN_CMP;
      end else if (timer && !pwm && io[2]) begin
        pin_fn = FN_CAP;
      end
    end
  endfunction

  // ==========================================================
  // Register file
  pfs_ctrl_t ctrl0_r;
  pfs_ctrl_t ctrl1_r;
  pfs_func_t func_r;
  pfs_io_t io_ab_r;
  pfs_io_t io_cd_r;
  logic [NPIN-1:0] out_dis_r;
  logic [NPIN-1:0] pwm_sel_r;
  logic [NPIN-1:0] port_dir_r;
  logic [NPIN-1:0] port_data_r;
  logic [CNT_W-1:0] gr_r [NPIN];
  logic [CNT_W-1:0] gr1_r;
  logic [CNT_W-1:0] cnt0_r;
  logic [CNT_W-1:0] cnt1_r;
  logic [CNT_W-1:0] cnt0_nxt;
  logic [CNT_W-1:0] cnt1_nxt;
  logic [NPIN-1:0] pin_prev_r;
  logic [NPIN-1:0] wave_r;
  logic [NPIN-1:0] wave_nxt;
  logic [NPIN-1:0] cap_w;
  logic [NPIN-1:0] is_out_w;
  logic [2:0] pio_w [NPIN];
  pfs_fn_t pin_fn_w [NPIN];
  logic wr_en;
  logic cnt0_wr;
  logic cnt1_wr;
  logic tick0;
  logic tick1;
  logic up0_r;
  logic combined;
  logic ext_mode;
  logic pa_rise;
  logic [DW-1:0] rd_mux;
  logic rd_ok;

  assign pready = 1'h1;
  assign wr_en = psel && penable && pwrite;
  assign cnt0_wr = wr_en && paddr == OFS_CNT0;
  assign cnt1_wr = wr_en && paddr == OFS_CNT1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_r <= '0;
      ctrl1_r <= '0;
      func_r <= FUNC_RST;
      io_ab_r <= '0;
      io_cd_r <= '0;
      out_dis_r <= OUT_DIS_RST;
      pwm_sel_r <= '0;
      port_dir_r <= '0;
      port_data_r <= '0;
      gr1_r <= GR_RST;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL0: ctrl0_r <= pwdata[$bits(pfs_ctrl_t)-1:0];
        OFS_CTRL1: ctrl1_r <= pwdata[$bits(pfs_ctrl_t)-1:0];
        OFS_FUNC: func_r <= pwdata[$bits(pfs_func_t)-1:0];
        OFS_IO_AB: io_ab_r <= pwdata[$bits(pfs_io_t)-1:0];
        OFS_IO_CD: io_cd_r <= pwdata[$bits(pfs_io_t)-1:0];
        OFS_OUT_DIS: out_dis_r <= pwdata[NPIN-1:0];
        OFS_PWM_SEL: pwm_sel_r <= {pwdata[NPIN-1:1], 1'h0};
        OFS_PORT_DIR: port_dir_r <= pwdata[NPIN-1:0];
        OFS_PORT_DATA: port_data_r <= pwdata[NPIN-1:0];
        OFS_GR1: gr1_r <= pwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Reads are answered with no wait state, so data is latched in setup.
  always_comb begin
    rd_ok = 1'h1;
    rd_mux = '0;
    case (paddr)
      OFS_CTRL0: rd_mux = DW'(ctrl0_r);
      OFS_CTRL1: rd_mux = DW'(ctrl1_r);
      OFS_FUNC: rd_mux = DW'(func_r);
      OFS_IO_AB: rd_mux = DW'(io_ab_r);
      OFS_IO_CD: rd_mux = DW'(io_cd_r);
      OFS_OUT_DIS: rd_mux = DW'(out_dis_r);
      OFS_PWM_SEL: rd_mux = DW'(pwm_sel_r);
      OFS_PORT_DIR: rd_mux = DW'(port_dir_r);
      OFS_PORT_DATA: rd_mux = DW'(port_data_r);
      OFS_GR1: rd_mux = DW'(gr1_r);
      OFS_CNT0: rd_mux = DW'(cnt0_r);
      OFS_CNT1: rd_mux = DW'(cnt1_r);
      OFS_STATUS: rd_mux = DW'({ch0_pin_in, op_clk_fast, pin_fn_w[3],
                                pin_fn_w[2], pin_fn_w[1], pin_fn_w[0]});
      default: rd_ok = 1'h0;
    endcase
    for (int k = 0; k < NPIN; k++) begin
      if (paddr == gr_addr(k)) begin
        rd_mux = DW'(gr_r[k]);
        rd_ok = 1'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'h0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? '0 : rd_mux;
      pslverr <= !rd_ok;
    end
  end

  // ==========================================================
  // Counters
  assign combined = !func_r.fixed_period_mode_bit ||
                    func_r.combination_mode_field != CMB_NONE;
  // The external clock path is closed in fixed-period mode.
  assign ext_mode = func_r.fixed_period_mode_bit &&
                    pin_fn_w[0] == FN_EXTCLK;
  assign pa_rise = ch0_pin_in[0] && !pin_prev_r[0];
  assign tick0 = ctrl0_r.run &&
      (ext_mode ? pa_rise
                : op_tick(ctrl0_r.count_source_sel,
                          fast_onchip_osc_clock));
  assign tick1 = combined ? tick0 :
      ctrl1_r.run && op_tick(ctrl1_r.count_source_sel,
                             fast_onchip_osc_clock);

  always_comb begin
    cnt0_nxt = cnt0_r;
    if (tick0) begin
      if (func_r.combination_mode_field[1]) begin
        cnt0_nxt = (up0_r && cnt0_r != gr_r[0]) || cnt0_r == '0 ?
                   cnt0_r + 16'h1 : cnt0_r - 16'h1;
      end else if ((ctrl0_r.clr_on_match || combined) &&
                   cnt0_r == gr_r[0]) begin
        cnt0_nxt = '0;
      end else begin
        cnt0_nxt = cnt0_r + 16'h1;
      end
    end
  end

  always_comb begin
    cnt1_nxt = cnt1_r;
    if (combined) begin
      cnt1_nxt = cnt0_nxt;
    end else if (tick1) begin
      cnt1_nxt = (ctrl1_r.clr_on_match && cnt1_r == gr1_r) ? '0 :
                 cnt1_r + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt0_r <= '0;
      cnt1_r <= '0;
      up0_r <= 1'h1;
      op_clk_fast <= '0;
      pin_prev_r <= '0;
    end else begin
      cnt0_r <= cnt0_wr ? pwdata[CNT_W-1:0] : cnt0_nxt;
      cnt1_r <= cnt1_wr ? pwdata[CNT_W-1:0] : cnt1_nxt;
      if (tick0 && cnt0_r == gr_r[0]) begin
        up0_r <= 1'h0;
      end else if (tick0 && cnt0_r == '0) begin
        up0_r <= 1'h1;
      end
      op_clk_fast <= {ctrl1_r.count_source_sel == CSS_FAST,
                      ctrl0_r.count_source_sel == CSS_FAST};
      pin_prev_r <= ch0_pin_in;
    end
  end

  // ==========================================================
  // Per-pin function, waveform and capture
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      if (gi < 2) begin : g_ab
        assign pio_w[gi] = gi == 0 ? io_ab_r.lo_io : io_ab_r.hi_io;
      end else begin : g_cd
        assign pio_w[gi] = gi == 2 ? io_cd_r.lo_io : io_cd_r.hi_io;
      end

      always_comb begin
        pin_fn_w[gi] = pin_fn(gi, out_dis_r[gi], func_r, pwm_sel_r[gi],
                              io_ab_r.pin_a_extra_ctrl, pio_w[gi]);
      end

      assign is_out_w[gi] = pin_fn_w[gi] inside
          {FN_CPWM, FN_RSYNC, FN_FIXED, FN_PWM, FN_CMP};
      // Capture edge: 100b rising, 101b falling, 11Xb both.
      assign cap_w[gi] = pin_fn_w[gi] == FN_CAP &&
          (pio_w[gi][1] ? ch0_pin_in[gi] != pin_prev_r[gi] :
           pio_w[gi][0] ? !ch0_pin_in[gi] && pin_prev_r[gi] :
           ch0_pin_in[gi] && !pin_prev_r[gi]);

      always_comb begin
        wave_nxt[gi] = wave_r[gi];
        case (pin_fn_w[gi])
          FN_CPWM: wave_nxt[gi] = {1'h0, cnt0_r} >=
                   {1'h0, gr_r[gi]} + {1'h0, gr1_r};
          FN_RSYNC: wave_nxt[gi] = cnt0_r < gr_r[gi];
          FN_PWM: wave_nxt[gi] = cnt0_r < gr_r[gi];
          FN_FIXED: wave_nxt[gi] =
                    cnt0_r < (gi == 0 ? gr_r[2] : gr1_r);
          FN_CMP: begin
            if (tick0 && cnt0_r == gr_r[gi]) begin
              wave_nxt[gi] = pio_w[gi] == IO_CMP_LOW ? 1'h0 :
                             pio_w[gi] == IO_CMP_HIGH ? 1'h1 :
                             !wave_r[gi];
            end
          end
          default: wave_nxt[gi] = wave_r[gi];
        endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wave_r[gi] <= 1'h0;
          ch0_pin_out[gi] <= 1'h0;
          ch0_pin_oe_n[gi] <= 1'h1;
        end else begin
          wave_r[gi] <= wave_nxt[gi];
          ch0_pin_out[gi] <= is_out_w[gi] ? wave_nxt[gi] :
                             port_data_r[gi];
          // Input functions trust the direction bit being input.
          ch0_pin_oe_n[gi] <= is_out_w[gi] ? 1'h0 :
                              !port_dir_r[gi];
        end
      end

      // A capture in the same cycle as a software write wins.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gr_r[gi] <= GR_RST;
        end else if (cap_w[gi]) begin
          gr_r[gi] <= cnt0_r;
        end else if (wr_en && paddr == gr_addr(gi)) begin
          gr_r[gi] <= pwdata[CNT_W-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  logic pwm_c_ref;
  logic rsync_b_ref;
  logic op0_tick;
  assign pwm_c_ref = cnt0_r < gr_r[2];
  assign rsync_b_ref = cnt0_r < gr_r[1];
  assign op0_tick = op_tick(ctrl0_r.count_source_sel, fast_onchip_osc_clock);

  property p_sys_clk;
    @(posedge pclk) disable iff (!presetn)
    ctrl0_r.count_source_sel <= CSS_MAX_SYS |=> !op_clk_fast[0];
  endproperty
  a_sys_clk: assert property (p_sys_clk)
    else $error("system clock not selected");

  property p_fast_clk;
    @(posedge pclk) disable iff (!presetn)
    ctrl1_r.count_source_sel == CSS_FAST |=> op_clk_fast[1];
  endproperty
  a_fast_clk: assert property (p_fast_clk)
    else $error("fast oscillator not selected");

  property p_fixed_a;
    @(posedge pclk) disable iff (!presetn)
    (!out_dis_r[0] && !func_r.fixed_period_mode_bit &&
     !func_r.ext_clock_select &&
     func_r.combination_mode_field == CMB_NONE) |=> !ch0_pin_oe_n[0];
  endproperty
  a_fixed_a: assert property (p_fixed_a)
    else $error("pin A not driving fixed-period wave");

  property p_cpwm;
    @(posedge pclk) disable iff (!presetn)
    (!out_dis_r[3] && func_r.combination_mode_field[1]) |=>
      !ch0_pin_oe_n[3];
  endproperty
  a_cpwm: assert property (p_cpwm)
    else $error("pin D not driving complementary wave");

  property p_rsync;
    @(posedge pclk) disable iff (!presetn)
    pin_fn_w[1] == FN_RSYNC |=> ch0_pin_out[1] == $past(rsync_b_ref);
  endproperty
  a_rsync: assert property (p_rsync)
    else $error("pin B reset-sync wave wrong");

  property p_pwm;
    @(posedge pclk) disable iff (!presetn)
    pin_fn_w[2] == FN_PWM |=>
      ch0_pin_out[2] == $past(pwm_c_ref) && !ch0_pin_oe_n[2];
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("pin C PWM wave wrong");

  property p_cmp_high;
    @(posedge pclk) disable iff (!presetn)
    (pin_fn_w[3] == FN_CMP && pio_w[3] == IO_CMP_HIGH && tick0 &&
     cnt0_r == gr_r[3]) |=> ch0_pin_out[3] ##1 ch0_pin_out[3] ||
     pin_fn_w[3] != FN_CMP || cnt0_r == gr_r[3];
  endproperty
  a_cmp_high: assert property (p_cmp_high)
    else $error("compare match did not set pin D");

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
    cap_w[1] |=> gr_r[1] == $past(cnt0_r);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy counter");

  property p_ext_count;
    @(posedge pclk) disable iff (!presetn)
    (ext_mode && ctrl0_r.run && pa_rise && !cnt0_wr &&
     !func_r.combination_mode_field[1]) |=> cnt0_r != $past(cnt0_r);
  endproperty
  a_ext_count: assert property (p_ext_count)
    else $error("external clock edge not counted");

  property p_no_ext_fixed;
    @(posedge pclk) disable iff (!presetn)
    (!func_r.fixed_period_mode_bit && !op0_tick && !cnt0_wr) |=>
      $stable(cnt0_r);
  endproperty
  a_no_ext_fixed: assert property (p_no_ext_fixed)
    else $error("counter moved without operation tick");

  property p_port;
    @(posedge pclk) disable iff (!presetn)
    pin_fn_w[3] == FN_PORT |=>
      ch0_pin_out[3] == $past(port_data_r[3]) &&
      ch0_pin_oe_n[3] == !$past(port_dir_r[3]);
  endproperty
  a_port: assert property (p_port)
    else $error("pin D not a plain port");

  c_capture: cover property (@(posedge pclk) disable iff (!presetn)
    cap_w[2]);
  c_cpwm: cover property (@(posedge pclk) disable iff (!presetn)
    pin_fn_w[1] == FN_CPWM ##1 !up0_r);
  c_ext: cover property (@(posedge pclk) disable iff (!presetn)
    ext_mode && pa_rise && ctrl0_r.run);
endmodule

// *** testbench/pfs_pin_env.sv ***
// Purpose: Model of the external lines on the four channel 0 pins.
// Assumes: Bench decides per pin whether an outside source drives it.
// Notes: A pin nobody drives toggles every cycle; it has no pull resistor.
`timescale 1ns/1ns
module pfs_pin_env
  import pfs_pkg::*;
(
  input wire logic pclk,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe_n,
  input wire logic [NPIN-1:0] drv_val,
  input wire logic [NPIN-1:0] drv_en,
  output logic [NPIN-1:0] pin_lvl
);
  // ==========================================================
  // Wire level
  // A floating pin must not look like a steady value to the sampler.
  logic [NPIN-1:0] float_r = 4'h0;
  always_ff @(posedge pclk) begin
    float_r <= ~float_r;
  end
  // The device wins while its enable is low; outside drive is for inputs.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (!pin_oe_n[i])
        pin_lvl[i] = pin_out[i];
      else if (drv_en[i])
        pin_lvl[i] = drv_val[i];
      else
        pin_lvl[i] = float_r[i];
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the channel 0 pin function select.
// Assumes: APB slave answers whenever it likes; bench waits for pready.
// Notes: Function codes are read back through the status register.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  import pfs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e, osc = 0;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe_n;
  logic [NPIN-1:0] drv_val = 4'h0, drv_en = 4'hF;
  logic [1:0] op_clk_fast;
  int error_cnt = 0, n_compared = 0, cyc = 0;

  // ==========================================================
  // Clock, timeout and instances
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    osc <= (cyc % 3 == 0);
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  pfs_pin_select i_pfs_pin_select (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_onchip_osc_clock(osc), .ch0_pin_in(pin_in),
    .ch0_pin_out(pin_out), .ch0_pin_oe_n(pin_oe_n),
    .op_clk_fast(op_clk_fast));
  pfs_pin_env i_pfs_pin_env (.pclk(pclk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .drv_val(drv_val), .drv_en(drv_en),
    .pin_lvl(pin_in));

  // ==========================================================
  // Shared tasks
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_vals();
    apb(0, OFS_FUNC, 0);
    `CHK("func rst", 32'h4, q)
    apb(0, OFS_OUT_DIS, 0);
    `CHK("outdis rst", 32'hF, q)
    apb(0, OFS_GR0, 0);
    `CHK("gr0 rst", 32'hFFFF, q)
    apb(0, OFS_STATUS, 0);
    `CHK("fn rst", 12'h000, q[11:0])
    `CHK("oe rst", 4'hF, pin_oe_n)
    apb(1, 8'h80, 32'h5);
    `CHK("unmapped err", 1'b1, e)
  endtask
  task automatic t_op_clock();
    for (int s = 0; s < 7; s++) begin
      apb(1, OFS_CTRL0, s);
      apb(1, OFS_CTRL1, s);
      edges(2);
      `CHK("op clk", {2{s == 6}}, op_clk_fast)
    end
    apb(1, OFS_CTRL0, 0);
    apb(1, OFS_CTRL1, 0);
  endtask
  // Columns: out disable, function, io A/B, io C/D, pwm select,
  // expected function codes and expected output enables.
  task automatic t_decode();
    logic [3:0] od[9] = '{0, 0, 0, 0, 0, 4'hF, 0, 0, 4'hF};
    logic [3:0] fn[9] = '{0, 2, 1, 4, 4, 4, 4'hE, 4'h8, 2};
    logic [6:0] ab[9] = '{0, 0, 0, 7'h09, 7'h21, 7'h54, 0, 0, 0};
    logic [6:0] cd[9] = '{0, 0, 0, 0, 7'h63, 7'h77, 0, 0, 0};
    logic [3:0] pw[9] = '{0, 0, 0, 4'hE, 0, 0, 0, 0, 0};
    logic [11:0] ex[9] = '{12'h01B, 12'h248, 12'h490, 12'h925, 12'hD68,
                           12'hDB6, 12'h24F, 12'h018, 12'h000};
    logic [3:0] oe[9] = '{4'hC, 4'h1, 4'h1, 4'h0, 4'h9, 4'hF, 4'h1,
                          4'hD, 4'hF};
    apb(1, OFS_PORT_DIR, 0);
    for (int i = 0; i < 9; i++) begin
      apb(1, OFS_OUT_DIS, od[i]);
      apb(1, OFS_FUNC, fn[i]);
      apb(1, OFS_IO_AB, ab[i]);
      apb(1, OFS_IO_CD, cd[i]);
      apb(1, OFS_PWM_SEL, pw[i]);
      apb(0, OFS_STATUS, 0);
      `CHK("fn codes", ex[i], q[11:0])
      `CHK("oe", oe[i], pin_oe_n)
    end
  endtask
  task automatic t_capture();
    do_reset();
    apb(1, OFS_IO_AB, 32'h40);
    apb(1, OFS_CNT0, 32'h1234);
    edges(3);
    drv_val[1] <= 1'b1;
    edges(3);
    apb(0, OFS_GR0 + OFS_GR_STEP, 0);
    `CHK("captured", 32'h1234, q)
    drv_val[1] <= 1'b0;
  endtask
  // Counter counts from 0 to the pin A register value of 0x10.
  task automatic t_compare();
    int n;
    do_reset();
    apb(1, OFS_OUT_DIS, 4'hE);
    apb(1, OFS_IO_AB, 32'h0A);
    apb(1, OFS_GR0, 32'h10);
    apb(1, OFS_CTRL0, 32'h08);
    n = 0;
    while (pin_out[0] !== 1'b1 && n < 40) begin
      edges(1);
      n++;
    end
    `CHK("match time", 1'b1, n >= 14 && n <= 18)
    `CHK("cmp drive", 1'b0, pin_oe_n[0])
  endtask
  task automatic t_ext_clock();
    do_reset();
    apb(1, OFS_FUNC, 32'hC);
    apb(1, OFS_CTRL0, 32'h08);
    repeat (5) begin
      drv_val[0] <= 1'b1;
      edges(2);
      drv_val[0] <= 1'b0;
      edges(2);
    end
    apb(0, OFS_CNT0, 0);
    `CHK("ext count", 32'h5, q)
  endtask
  // Period of eight: pin A high below 3, pin B high below 5.
  task automatic t_fixed();
    int na, nb;
    logic [DW-1:0] c0;
    do_reset();
    apb(1, OFS_OUT_DIS, 4'hC);
    apb(1, OFS_FUNC, 0);
    apb(1, OFS_GR0, 32'h7);
    apb(1, OFS_GR0 + OFS_GR_STEP + OFS_GR_STEP, 32'h3);
    apb(1, OFS_GR1, 32'h5);
    apb(1, OFS_CTRL0, 32'h08);
    na = 0;
    nb = 0;
    edges(4);
    repeat (8) begin
      edges(1);
      na += pin_out[0];
      nb += pin_out[1];
    end
    `CHK("fixed A highs", 3, na)
    `CHK("fixed B highs", 5, nb)
    apb(1, OFS_CTRL0, 0);
    apb(0, OFS_CNT0, 0);
    c0 = q;
    apb(0, OFS_CNT1, 0);
    `CHK("combined count", c0, q)
  endtask
  // Triangle 0 to 7 and back spends nine of fourteen steps at 3 or more.
  task automatic t_cpwm();
    int nb;
    do_reset();
    apb(1, OFS_OUT_DIS, 4'h1);
    apb(1, OFS_GR0, 32'h7);
    apb(1, OFS_GR0 + OFS_GR_STEP, 32'h2);
    apb(1, OFS_GR1, 32'h1);
    apb(1, OFS_FUNC, 32'h2);
    apb(1, OFS_CTRL0, 32'h08);
    nb = 0;
    edges(4);
    repeat (14) begin
      edges(1);
      nb += pin_out[1];
    end
    `CHK("cpwm B highs", 9, nb)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    t_op_clock();
    t_decode();
    t_capture();
    t_compare();
    t_ext_clock();
    t_fixed();
    t_cpwm();
    final_report();
  end
endmodule
